/* File: core/cp_resp_handler.sv */
// coprocessor response primitive handler on the main processor side
// assumes CIR bus and primitive source run on core_clk_i, wishbone master too
//
// Overview of operation
// [RULE1] sr/scan primitive with direction 1 flushes prefetch, refills from scan pointer.
// [RULE2] trace-on-flow at instruction start plus direction 1 arms a trace.
// [RULE3] armed trace is taken only once coprocessor reports instruction done.
// [RULE4] status word trace field loaded now applies from next instruction.
// [RULE5] preinstruction exception uses primitive vector and preinstruction frame.
// [RULE6] preinstruction exception accepted in general and conditional categories.
// [RULE7] acknowledge mask written to control CIR before exception processing.
// [RULE8] function bits 13-8 of 00 or 3F raise protocol violation.
// [RULE9] coprocessor should reset only on external reset, not software reset.
// [RULE10] sr/scan primitive with direction 0 keeps prefetch, no refill.
// [RULE11] scan select 1, direction 1: read status word, then scan pointer.
// [RULE12] the acknowledge mask sets the exception acknowledge bit.
`include "cp_resp_regs.svh"

module cp_resp_handler #(
    parameter logic [3:0] SRSCAN_CODE = 4'h7,
    parameter logic [5:0] PREEXC_CODE = 6'h1C
) (
    // clock and reset
    input  wire logic                  core_clk_i,
    input  wire logic                  arst_n_i,
    // wishbone slave
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    input  wire logic                  wb_we_i,
    input  wire logic [7:0]            wb_adr_i,
    input  wire logic [3:0]            wb_sel_i,
    input  wire logic [31:0]           wb_dat_i,
    output logic      [31:0]           wb_dat_o,
    output logic                       wb_ack_o,
    output logic                       irq_o,
    // primitive source
    input  wire logic                  prim_valid_i,
    input  wire logic [15:0]           prim_i,
    output logic                       prim_ready_o,
    input  wire logic                  instr_start_i,
    input  wire logic                  instr_done_i,
    // CIR access
    output cp_resp_pkg::cir_req_t      cir_o,
    input  wire logic                  cir_ack_i,
    input  wire logic [31:0]           cir_rdata_i,
    // processor core effects
    output cp_resp_pkg::refill_t       refill_o,
    output cp_resp_pkg::exc_t          exc_o,
    output logic                       trace_exc_o,
    output logic                       protviol_o
);

    ////////////////////////////////////////////////////////////////////////
    // declarations

    cp_resp_pkg::state_t state_q;
    cp_resp_pkg::cir_req_t cir_q;
    logic [15:0]          sword_q;
    logic [31:0]          scan_q;
    logic                 enable_q;
    logic [`EV_W-1:0]     stat_q;
    logic [`EV_W-1:0]     mask_q;
    logic                 trace_start_q;
    logic                 trace_pend_q;
    logic                 dr_q;
    logic                 sp_q;
    logic [7:0]           vec_q;
    logic                 ack_q;
    logic [31:0]          rdat_q;
    logic                 flush_q;
    logic                 super_q;
    logic [31:0]          raddr_q;
    logic                 exc_q;
    logic                 trace_q;
    logic                 pv_q;
    logic                 take;
    logic [5:0]           fn;
    logic                 is_bad;
    logic                 is_srscan;
    logic                 is_preexc;
    logic                 wb_req;
    logic                 wb_wr;
    logic                 cir_done;
    logic [`EV_W-1:0]     ev;
    logic                 sw_load;
    logic                 sp_load;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    function automatic cp_resp_pkg::cir_req_t cir_cmd(input logic        we,
                                                      input logic [7:0]  addr,
                                                      input logic [31:0] wdata);
        cp_resp_pkg::cir_req_t c;
        c.req   = 1'b1;
        c.we    = we;
        c.addr  = addr;
        c.wdata = wdata;
        return c;
    endfunction : cir_cmd

    ////////////////////////////////////////////////////////////////////////
    // primitive decode

    assign fn           = prim_i[13:8];
    assign prim_ready_o = (state_q == cp_resp_pkg::ST_IDLE) && enable_q;
    assign take         = prim_valid_i && prim_ready_o;
    assign is_bad       = (fn == `PRIM_FN_BAD_LO) || (fn == `PRIM_FN_BAD_HI); // RULE8
    assign is_srscan    = !is_bad && (prim_i[12:9] == SRSCAN_CODE);
    // no category check: taken in general and conditional alike
    assign is_preexc    = !is_bad && (fn == PREEXC_CODE); // RULE6
    assign cir_done     = cir_q.req && cir_ack_i;
    assign sw_load      = cir_done && (state_q == cp_resp_pkg::ST_RD_SW);
    assign sp_load      = cir_done && (state_q == cp_resp_pkg::ST_RD_SP);

    ////////////////////////////////////////////////////////////////////////
    // sequencer and CIR master

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_q <= cp_resp_pkg::ST_IDLE;
            cir_q   <= '0;
            dr_q    <= 1'b0;
            sp_q    <= 1'b0;
            vec_q   <= 8'h00;
        end else begin
            unique case (state_q)
                cp_resp_pkg::ST_IDLE: begin
                    if (take && is_srscan) begin
                        dr_q <= prim_i[`PRIM_DR_BIT];
                        sp_q <= prim_i[`PRIM_SP_BIT];
                        if (prim_i[`PRIM_DR_BIT]) begin
                            state_q <= cp_resp_pkg::ST_RD_SW; // RULE11
                            cir_q   <= cir_cmd(1'b0, `CIR_OPERAND, 32'h0000_0000);
                        end else if (prim_i[`PRIM_SP_BIT]) begin
                            state_q <= cp_resp_pkg::ST_WR_IA;
                            cir_q   <= cir_cmd(1'b1, `CIR_INSTR_ADDR, scan_q);
                        end else begin
                            state_q <= cp_resp_pkg::ST_WR_SW;
                            cir_q   <= cir_cmd(1'b1, `CIR_OPERAND, {sword_q, 16'h0000});
                        end
                    end else if (take && is_preexc) begin
                        vec_q   <= prim_i[7:0]; // RULE5
                        state_q <= cp_resp_pkg::ST_WR_ACK;
                        cir_q   <= cir_cmd(1'b1, `CIR_CONTROL,
                                           {`CTRL_ACK_MASK, 16'h0000}); // RULE7 RULE12
                    end
                end
                cp_resp_pkg::ST_RD_SW: begin
                    if (cir_done) begin
                        if (sp_q) begin
                            state_q <= cp_resp_pkg::ST_RD_SP; // RULE11
                            cir_q   <= cir_cmd(1'b0, `CIR_INSTR_ADDR, 32'h0000_0000);
                        end else begin
                            state_q <= cp_resp_pkg::ST_FLUSH;
                            cir_q   <= '0;
                        end
                    end
                end
                cp_resp_pkg::ST_RD_SP: begin
                    if (cir_done) begin
                        state_q <= cp_resp_pkg::ST_FLUSH;
                        cir_q   <= '0;
                    end
                end
                cp_resp_pkg::ST_WR_IA: begin
                    if (cir_done) begin
                        state_q <= cp_resp_pkg::ST_WR_SW;
                        cir_q   <= cir_cmd(1'b1, `CIR_OPERAND, {sword_q, 16'h0000});
                    end
                end
                cp_resp_pkg::ST_WR_SW: begin
                    if (cir_done) begin
                        state_q <= cp_resp_pkg::ST_IDLE; // RULE10
                        cir_q   <= '0;
                    end
                end
                cp_resp_pkg::ST_FLUSH: begin
                    state_q <= cp_resp_pkg::ST_IDLE;
                end
                cp_resp_pkg::ST_WR_ACK: begin
                    if (cir_done) begin
                        state_q <= cp_resp_pkg::ST_EXC; // RULE7
                        cir_q   <= '0;
                    end
                end
                cp_resp_pkg::ST_EXC: begin
                    state_q <= cp_resp_pkg::ST_IDLE;
                end
            endcase
        end
    end

    assign cir_o = cir_q;

    ////////////////////////////////////////////////////////////////////////
    // status word and scan pointer; hardware load beats software write

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sword_q <= `SW_RESET;
        end else if (sw_load) begin
            sword_q <= cir_rdata_i[31:16];
        end else if (wb_wr && wb_adr_i == `REG_SWORD) begin
            sword_q <= 16'(merge({16'h0000, sword_q}, wb_dat_i, wb_sel_i));
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            scan_q <= 32'h0000_0000;
        end else if (sp_load) begin
            scan_q <= cir_rdata_i;
        end else if (wb_wr && wb_adr_i == `REG_SCAN_PTR) begin
            scan_q <= merge(scan_q, wb_dat_i, wb_sel_i);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // trace on change of flow

    // trace mode sampled at instruction start, later loads wait a turn
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            trace_start_q <= 1'b0;
        end else if (instr_start_i) begin
            trace_start_q <= (sword_q[`SW_TRACE_HI:`SW_TRACE_LO] == `SW_TRACE_FLOW); // RULE4
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            trace_pend_q <= 1'b0;
            trace_q      <= 1'b0;
        end else begin
            trace_q <= 1'b0;
            if (take && is_srscan && prim_i[`PRIM_DR_BIT] && trace_start_q) begin
                trace_pend_q <= 1'b1; // RULE2
            end else if (instr_done_i && trace_pend_q) begin
                trace_pend_q <= 1'b0; // RULE3
                trace_q      <= 1'b1;
            end
        end
    end

    assign trace_exc_o = trace_q;

    ////////////////////////////////////////////////////////////////////////
    // pipeline refill, exception start, protocol violation

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            flush_q <= 1'b0;
            super_q <= 1'b0;
            raddr_q <= 32'h0000_0000;
        end else begin
            flush_q <= 1'b0;
            if (state_q == cp_resp_pkg::ST_FLUSH && dr_q) begin
                flush_q <= 1'b1; // RULE1
                super_q <= sword_q[`SW_SUPER_BIT];
                raddr_q <= scan_q;
            end
        end
    end

    assign refill_o = '{flush: flush_q, supv: super_q, addr: raddr_q};

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            exc_q <= 1'b0;
            pv_q  <= 1'b0;
        end else begin
            exc_q <= (state_q == cp_resp_pkg::ST_EXC); // RULE5
            pv_q  <= take && is_bad; // RULE8
        end
    end

    assign exc_o      = '{start: exc_q, frame: `FRAME_PREINSTR, vector: vec_q};
    assign protviol_o = pv_q;

    ////////////////////////////////////////////////////////////////////////
    // wishbone slave

    assign wb_req = wb_cyc_i && wb_stb_i && !ack_q;
    assign wb_wr  = wb_req && wb_we_i;

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ack_q  <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            ack_q <= wb_req;
            if (wb_req && !wb_we_i) begin
                unique case (wb_adr_i)
                    `REG_CTRL:     rdat_q <= {31'h0000_0000, enable_q};
                    `REG_IRQ_STAT: rdat_q <= {28'h000_0000, stat_q};
                    `REG_IRQ_MASK: rdat_q <= {28'h000_0000, mask_q};
                    `REG_SWORD:    rdat_q <= {16'h0000, sword_q};
                    `REG_SCAN_PTR: rdat_q <= scan_q;
                    `REG_INFO:     rdat_q <= {20'h0_0000, vec_q, 1'b0,
                                              prim_ready_o, trace_start_q, trace_pend_q};
                    default:       rdat_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            enable_q <= 1'b1;
            mask_q   <= '0;
        end else if (wb_wr && wb_sel_i[0]) begin
            if (wb_adr_i == `REG_CTRL) begin
                enable_q <= wb_dat_i[0];
            end
            if (wb_adr_i == `REG_IRQ_MASK) begin
                mask_q <= wb_dat_i[`EV_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt status, set beats write-one-to-clear

    always_comb begin
        ev               = '0;
        ev[`EV_FLUSH]    = flush_q;
        ev[`EV_TRACE]    = trace_q;
        ev[`EV_PREEXC]   = exc_q;
        ev[`EV_PROTVIOL] = pv_q;
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            stat_q <= '0;
        end else if (wb_wr && wb_sel_i[0] && wb_adr_i == `REG_IRQ_STAT) begin
            stat_q <= (stat_q & ~wb_dat_i[`EV_W-1:0]) | ev;
        end else begin
            stat_q <= stat_q | ev;
        end
    end

    assign irq_o = |(stat_q & mask_q);

endmodule : cp_resp_handler

/* File: core/cp_resp_regs.svh */
// constants for the coprocessor response primitive handler
// assumes a 32-bit classic wishbone slave and byte-addressed CIR offsets
`ifndef CP_RESP_REGS_SVH
`define CP_RESP_REGS_SVH

// wishbone register byte offsets
`define REG_CTRL          8'h00
`define REG_IRQ_STAT      8'h04
`define REG_IRQ_MASK      8'h08
`define REG_SWORD         8'h0C
`define REG_SCAN_PTR      8'h10
`define REG_INFO          8'h14

// event bit positions in status and mask
`define EV_FLUSH          0
`define EV_TRACE          1
`define EV_PREEXC         2
`define EV_PROTVIOL       3
`define EV_W              4

// CIR byte offsets
`define CIR_CONTROL       8'h02
`define CIR_OPERAND       8'h10
`define CIR_INSTR_ADDR    8'h18

// primitive fields
`define PRIM_DR_BIT       13
`define PRIM_SP_BIT       8
`define PRIM_FN_BAD_LO    6'h00
`define PRIM_FN_BAD_HI    6'h3F

// status word fields
`define SW_TRACE_HI       15
`define SW_TRACE_LO       14
`define SW_SUPER_BIT      13
`define SW_TRACE_FLOW     2'h1
`define SW_RESET          16'h2700

// control CIR acknowledge mask, exception_ack_bit at bit 1
`define CTRL_ACK_MASK     16'h0002

// preinstruction stack frame format code
`define FRAME_PREINSTR    4'h0

`endif

/* File: core/cp_resp_pkg.sv */
// types for the coprocessor response primitive handler
// assumes nothing beyond the constants header
package cp_resp_pkg;

    typedef struct packed {
        logic        req;
        logic        we;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } cir_req_t;

    typedef struct packed {
        logic        flush;
        logic        supv;
        logic [31:0] addr;
    } refill_t;

    typedef struct packed {
        logic       start;
        logic [3:0] frame;
        logic [7:0] vector;
    } exc_t;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_RD_SW  = 3'b001,
        ST_RD_SP  = 3'b010,
        ST_WR_IA  = 3'b011,
        ST_WR_SW  = 3'b100,
        ST_FLUSH  = 3'b101,
        ST_WR_ACK = 3'b110,
        ST_EXC    = 3'b111
    } state_t;

endpackage : cp_resp_pkg

/* File: bench/cp_resp_handler_props.sv */
// port assertions for the response primitive handler
// assumes binding onto cp_resp_handler, one clock domain
module cp_resp_handler_props #(
    parameter logic [5:0] PREEXC_CODE = 6'h1C
) (
    input wire logic                  core_clk_i,
    input wire logic                  arst_n_i,
    input wire logic                  prim_valid_i,
    input wire logic [15:0]           prim_i,
    input wire logic                  prim_ready_o,
    input wire logic                  instr_done_i,
    input wire cp_resp_pkg::cir_req_t cir_o,
    input wire logic                  cir_ack_i,
    input wire logic [31:0]           cir_rdata_i,
    input wire cp_resp_pkg::refill_t  refill_o,
    input wire cp_resp_pkg::exc_t     exc_o,
    input wire logic                  trace_exc_o,
    input wire logic                  protviol_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic        take, bad, rd_ack, rd_sw, rd_ptr, wr_ctl, sp_q;
    logic [15:0] sw_q;
    logic [31:0] ptr_q;
    logic [7:0]  vec_q;
    assign take   = prim_valid_i && prim_ready_o;
    assign bad    = take && (prim_i[13:8] == 6'h00 || prim_i[13:8] == 6'h3F);
    assign rd_ack = cir_o.req && cir_ack_i && !cir_o.we;
    assign rd_sw  = rd_ack && cir_o.addr == 8'h10;
    assign rd_ptr = rd_ack && cir_o.addr == 8'h18;
    assign wr_ctl = cir_o.req && cir_ack_i && cir_o.we && cir_o.addr == 8'h02;
    // last loaded values, compared with what the refill and exception carry
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sp_q  <= 1'b0;
            sw_q  <= 16'h0000;
            ptr_q <= 32'h0000_0000;
            vec_q <= 8'h00;
        end else begin
            if (take) sp_q <= prim_i[8];
            if (rd_sw) sw_q <= cir_rdata_i[31:16];
            if (rd_ptr) ptr_q <= cir_rdata_i;
            if (take && prim_i[13:8] == PREEXC_CODE) vec_q <= prim_i[7:0];
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!arst_n_i);
    sequence s_refill;
        ##[1:2] refill_o.flush && refill_o.addr == ptr_q && refill_o.supv == sw_q[13];
    endsequence
    sequence s_exc_go;
        ##[1:2] exc_o.start && exc_o.frame == 4'h0;
    endsequence
    protviol_a: assert property (protviol_o == $past(bad))
        else $error("protocol violation pulse wrong");
    ack_write_a: assert property (take && prim_i[13:8] == PREEXC_CODE |=> cir_o.req && cir_o.we
        && cir_o.addr == 8'h02 && cir_o.wdata == 32'h0002_0000)
        else $error("acknowledge write wrong");
    exc_start_a: assert property (wr_ctl |-> s_exc_go)
        else $error("exception start missing");
    exc_vec_a: assert property (exc_o.start |-> exc_o.vector == vec_q)
        else $error("exception vector wrong");
    ptr_flush_a: assert property (rd_ptr |-> s_refill)
        else $error("refill missing or wrong");
    flush_cause_a: assert property (refill_o.flush |-> $past(rd_ack) || $past(rd_ack, 2))
        else $error("flush without a read transfer");
    rd_order_a: assert property (rd_sw && sp_q |=> cir_o.req && !cir_o.we
        && cir_o.addr == 8'h18)
        else $error("pointer read not next");
    trace_done_a: assert property (trace_exc_o |-> $past(instr_done_i)
        || $past(instr_done_i, 2))
        else $error("trace before instruction done");
endmodule : cp_resp_handler_props

/* File: bench/cir_partner.sv */
// coprocessor model answering the interface register accesses
// assumes each access is held until acknowledged
module cir_partner (
    // clock and reset
    input  wire logic                  core_clk_i,
    input  wire logic                  arst_n_i,
    // access from handler
    input  wire cp_resp_pkg::cir_req_t cir_i,
    output logic                       cir_ack_o,
    output logic [31:0]                cir_rdata_o,
    // scenario control and record
    input  wire logic [3:0]            delay_i,
    input  wire logic [15:0]           sword_i,
    input  wire logic [31:0]           ptr_i,
    output logic [7:0]                 wr_addr_o,
    output logic [31:0]                wr_data_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] wait_q;
    // cleared by the external reset alone
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wait_q      <= 4'h0;
            cir_ack_o   <= 1'b0;
            cir_rdata_o <= 32'h0000_0000;
            wr_addr_o   <= 8'h00;
            wr_data_o   <= 32'h0000_0000;
        end else if (cir_ack_o || !cir_i.req) begin
            cir_ack_o   <= 1'b0;
            wait_q      <= 4'h0;
            cir_rdata_o <= ~cir_rdata_o;
        end else if (wait_q != delay_i) begin
            wait_q <= wait_q + 4'h1;
        end else begin
            cir_ack_o   <= 1'b1;
            cir_rdata_o <= (cir_i.addr == 8'h18) ? ptr_i : {sword_i, 16'h0000};
            if (cir_i.we) wr_addr_o <= cir_i.addr;
            if (cir_i.we) wr_data_o <= cir_i.wdata;
        end
    end
endmodule : cir_partner

/* File: bench/tb_cp_resp_handler.sv */
// self-checking bench for the response primitive handler
// assumes cir_partner on the coprocessor side, bench as wishbone master
module tb_cp_resp_handler;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, we = 1'b0;
    logic        pvalid = 1'b0, istart = 1'b0, idone = 1'b0;
    logic        ack, irq, ready, cack, tr, pv;
    logic [7:0]  adr = 8'h00, wa;
    logic [31:0] wdat = 32'h0, ptr = 32'h0, rdat, crd, wd, rd;
    logic [15:0] prim = 16'h0000, sw = 16'h0000;
    logic [3:0]  dly = 4'h1;
    cp_resp_pkg::cir_req_t cir;
    cp_resp_pkg::refill_t  refill, r_last;
    cp_resp_pkg::exc_t     exc, e_last;
    int errors = 0, cmp_count = 0, n_fl = 0, n_tr = 0, n_pv = 0, n_ex = 0;
    cp_resp_handler cp_resp_handler_inst (.core_clk_i(clk), .arst_n_i(rst_n),
        .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq),
        .prim_valid_i(pvalid), .prim_i(prim), .prim_ready_o(ready), .instr_start_i(istart),
        .instr_done_i(idone), .cir_o(cir), .cir_ack_i(cack), .cir_rdata_i(crd),
        .refill_o(refill), .exc_o(exc), .trace_exc_o(tr), .protviol_o(pv));
    cir_partner cir_partner_inst (.core_clk_i(clk), .arst_n_i(rst_n), .cir_i(cir),
        .cir_ack_o(cack), .cir_rdata_o(crd), .delay_i(dly), .sword_i(sw), .ptr_i(ptr),
        .wr_addr_o(wa), .wr_data_o(wd));
    initial begin
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        n_fl += (refill.flush === 1'b1);
        n_tr += (tr === 1'b1);
        n_pv += (pv === 1'b1);
        n_ex += (exc.start === 1'b1);
        if (refill.flush === 1'b1) r_last = refill;
        if (exc.start === 1'b1) e_last = exc;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_sim
    task automatic hang(input string s);
        errors++;
        $display("mismatch at %0t: %s timed out", $time, s);
        end_sim();
    endtask : hang
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string s);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: %s got %h expected %h", $time, s, got, exp);
        end
    endtask : check
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        cyc  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 40);
        rd = rdat;
        cyc <= 1'b0;
        if (ack !== 1'b1) hang("bus");
    endtask : wb
    // offer one primitive, then wait for the handler to go idle again
    task automatic send(input logic [15:0] w);
        int n;
        @(posedge clk);
        pvalid <= 1'b1;
        prim   <= w;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ready !== 1'b1 && n < 40);
        pvalid <= 1'b0;
        do begin
            @(posedge clk);
            n++;
        end while (ready !== 1'b1 && n < 80);
        if (ready !== 1'b1) hang("primitive");
        repeat (4) @(posedge clk);
    endtask : send
    task automatic pulse(input logic done);
        @(posedge clk);
        istart <= !done;
        idone  <= done;
        @(posedge clk);
        istart <= 1'b0;
        idone  <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : pulse
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_prot;
        logic [15:0] codes [4] = '{16'h0000, 16'h3F00, 16'hFF12, 16'h2000};
        int base;
        wb(1'b0, 8'h0C, 32'h0);
        check(rd, 32'h0000_2700, "status word reset");
        wb(1'b0, 8'h24, 32'h0);
        check(rd, 32'h0, "unmapped read");
        wb(1'b1, 8'h08, 32'hF);
        foreach (codes[i]) begin
            base = n_pv;
            send(codes[i]);
            check(n_pv, base + (i < 3), "violation count");
        end
        check(irq, 1'b1, "irq raised");
        wb(1'b1, 8'h08, 32'h0);
        check(irq, 1'b0, "irq masked");
        wb(1'b1, 8'h00, 32'h0);
        check(ready, 1'b0, "primitive refused while disabled");
        wb(1'b1, 8'h00, 32'h1);
        check(ready, 1'b1, "primitive accepted when enabled");
        wb(1'b1, 8'h04, 32'hF);
        wb(1'b0, 8'h04, 32'h0);
        check(rd, 32'h0, "status cleared");
        $display("violation test done");
    endtask : t_prot
    task automatic t_scan;
        int base;
        sw  <= 16'h2000;
        ptr <= 32'h0001_F0A4;
        base = n_fl;
        send(16'h2F00);
        check(n_fl, base + 1, "flush count");
        check(r_last.addr, 32'h0001_F0A4, "refill address");
        check(r_last.supv, 1'b1, "refill space");
        wb(1'b0, 8'h0C, 32'h0);
        check(rd, 32'h0000_2000, "status word load");
        wb(1'b0, 8'h10, 32'h0);
        check(rd, 32'h0001_F0A4, "pointer load");
        send(16'h2E00);
        check(n_fl, base + 2, "flush after status only");
        check(r_last.addr, 32'h0001_F0A4, "refill address kept");
        send(16'h0F00);
        check(n_fl, base + 2, "no flush on store");
        check(wd, 32'h2000_0000, "stored status");
        $display("transfer test done");
    endtask : t_scan
    task automatic t_trace;
        int base;
        wb(1'b1, 8'h0C, 32'h0000_4000);
        sw <= 16'h0000;
        pulse(1'b0);
        base = n_tr;
        send(16'h2F00);
        check(n_tr, base, "trace held");
        pulse(1'b1);
        check(n_tr, base + 1, "trace taken");
        sw <= 16'h4000;
        pulse(1'b0);
        send(16'h2F00);
        pulse(1'b1);
        check(n_tr, base + 1, "new mode deferred");
        $display("trace test done");
    endtask : t_trace
    task automatic t_exc;
        logic [7:0] vec [2] = '{8'hA5, 8'h3C};
        int base;
        foreach (vec[i]) begin
            dly <= 4'(i * 3);
            base = n_ex;
            send({8'h1C, vec[i]});
            check(wa, 8'h02, "acknowledge target");
            check(wd, 32'h0002_0000, "acknowledge mask");
            check(n_ex, base + 1, "exception start");
            check(e_last.vector, vec[i], "vector");
            check(e_last.frame, 4'h0, "frame format");
        end
        wb(1'b0, 8'h04, 32'h0);
        check(rd[2], 1'b1, "exception status");
        $display("exception test done");
    endtask : t_exc
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        t_prot();
        t_scan();
        t_trace();
        t_exc();
        end_sim();
    end
endmodule : tb_cp_resp_handler
bind cp_resp_handler cp_resp_handler_props #(.PREEXC_CODE(PREEXC_CODE)) props_inst (
    .core_clk_i, .arst_n_i, .prim_valid_i, .prim_i, .prim_ready_o, .instr_done_i, .cir_o,
    .cir_ack_i, .cir_rdata_i, .refill_o, .exc_o, .trace_exc_o, .protviol_o);
